// *** tcsc_ctrl.sv ***
// Line fill and line state sequencer for a split L1 and unified L2 cache
// Contract
// - Hardware fill takes the demanded line first, then its sector mate.
// - Demand fill and mate prefetch are two 32-byte burst reads.
// - Wait states when not ready, higher priority pending, or next-address unseen.
// - Sampled address hold or back-off delays the following burst.
// - Software prefetch loads only the addressed line into data L1 and L2.
// - Uncacheable double miss read: one single read, both levels stay invalid.
// - Burst fill only with cacheable-cycle low and cache-enable sampled active.
// - Fill is exclusive if writethrough low and writeback input high, else shared.
// - Writeback input assumed constant per line; no reconciliation across accesses.
// - Instruction L1 treats exclusive and shared alike; four states M E S I.
// - L1 read miss, L2 hit: fill L1, copy E or S to both.
// - Modified L2 read: data L1 gets M, L2 E; instruction L1 E, L2 M.
// - Never exclusive in data L1 while modified in L2.
// - Non-allocating double write miss: one single write, both invalid.
// - Allocating writeback write miss: burst fill, write L1, L1 M and L2 E.
// - Allocating writethrough write miss: burst fill, write both, single write, shared.
// - Write hit shared L1: write plus bus write; E or M L1 becomes M.
// - Write hit shared in both: write both, bus write, states from writeback inputs.
// - Non-allocating L1 miss L2 hit write: L2 written, E or M to M, S adds write.
// - Allocating L1 miss on E or M L2: fill, write L1, M and E.
`timescale 1ns/1ps
module tcsc_ctrl #(
  parameter int ADDR_W = tcsc_pkg::LINE_ADDR_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqInstr,
  input wire logic reqSwPrefetch,
  input wire logic reqCacheable,
  input wire logic reqWriteAlloc,
  input wire logic reqPageWt,
  input wire logic [ADDR_W-1:0] reqLineAddr,
  input wire tcsc_pkg::tcsc_mesi_e reqL1State,
  input wire tcsc_pkg::tcsc_mesi_e reqL2State,
  output logic busReq,
  output logic [ADDR_W-1:0] busAddr,
  output logic busBurst,
  output logic busWrite,
  output logic cacheCycle_n,
  output logic pageWritethrough,
  input wire logic busReady,
  input wire logic busDone,
  input wire logic priorityPending,
  input wire logic nextCycleRequest_n,
  input wire logic addrBusHold,
  input wire logic busBackoff_n,
  input wire logic lineCacheEnable_n,
  input wire logic writebackNotWritethrough,
  output logic updValid,
  output logic [ADDR_W-1:0] updAddr,
  output tcsc_pkg::tcsc_mesi_e updL1State,
  output tcsc_pkg::tcsc_mesi_e updL2State,
  output logic updL1,
  output logic updL2,
  output logic updL1Write,
  output logic updL2Write,
  output logic updInstr,
  output logic opDone
);

  tcsc_plan_if plan ();

  tcsc_pkg::tcsc_state_e state_ff, nxt_state;
  logic wr_ff, nxt_wr;
  logic instr_ff, nxt_instr;
  logic sw_ff, nxt_sw;
  logic cach_ff, nxt_cach;
  logic alloc_ff, nxt_alloc;
  logic pwt_ff, nxt_pwt;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  tcsc_pkg::tcsc_mesi_e l1_ff, nxt_l1;
  tcsc_pkg::tcsc_mesi_e l2_ff, nxt_l2;
  logic fillEx_ff, nxt_fillEx;
  logic kenOk_ff, nxt_kenOk;
  logic busReq_ff, nxt_busReq;
  logic [ADDR_W-1:0] busAddr_ff, nxt_busAddr;
  logic busBurst_ff, nxt_busBurst;
  logic busWrite_ff, nxt_busWrite;
  logic cacheN_ff, nxt_cacheN;
  logic updValid_ff, nxt_updValid;
  logic [ADDR_W-1:0] updAddr_ff, nxt_updAddr;
  tcsc_pkg::tcsc_mesi_e updL1St_ff, nxt_updL1St;
  tcsc_pkg::tcsc_mesi_e updL2St_ff, nxt_updL2St;
  logic updL1_ff, nxt_updL1;
  logic updL2_ff, nxt_updL2;
  logic updL1Wr_ff, nxt_updL1Wr;
  logic updL2Wr_ff, nxt_updL2Wr;
  logic opDone_ff, nxt_opDone;
  logic startOk;
  logic kenFail;
  logic fillNow;
  logic [ADDR_W-1:0] mateAddr;
  tcsc_pkg::tcsc_mesi_e fx;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  tcsc_state_calc u_calc (
    .isWrite(wr_ff),
    .isInstr(instr_ff),
    .isSwPrefetch(sw_ff),
    .isCacheable(cach_ff),
    .writeAlloc(alloc_ff),
    .fillExcl(fillNow),
    .l1State(l1_ff),
    .l2State(l2_ff),
    .plan(plan.calc)
  );

  tcsc_bus_gate u_gate (
    .clock(clock),
    .rst_n(rst_n),
    .busReady(busReady),
    .priorityPending(priorityPending),
    .nextCycleRequest_n(nextCycleRequest_n),
    .addrBusHold(addrBusHold),
    .busBackoff_n(busBackoff_n),
    .inBurst((state_ff == tcsc_pkg::ST_DEMAND && busBurst_ff) || state_ff == tcsc_pkg::ST_AFTER),
    .between(state_ff == tcsc_pkg::ST_GAP),
    .startOk(startOk)
  );

  // Sector mate differs only in the line-select bit
  assign mateAddr = addr_ff ^ ADDR_W'(1 << tcsc_pkg::SECTOR_SEL_BIT);
  assign kenFail = plan.burst && !kenOk_ff;
  assign fx = fillEx_ff ? tcsc_pkg::MESI_E : tcsc_pkg::MESI_S;
  // Single cycles ending in the demand state report with the writeback sample taken at their own done
  assign fillNow = (state_ff == tcsc_pkg::ST_DEMAND) ? (!pwt_ff && writebackNotWritethrough)
    : fillEx_ff;
  assign reqReady = (state_ff == tcsc_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_wr = wr_ff;
    nxt_instr = instr_ff;
    nxt_sw = sw_ff;
    nxt_cach = cach_ff;
    nxt_alloc = alloc_ff;
    nxt_pwt = pwt_ff;
    nxt_addr = addr_ff;
    nxt_l1 = l1_ff;
    nxt_l2 = l2_ff;
    nxt_fillEx = fillEx_ff;
    nxt_kenOk = kenOk_ff;
    nxt_busReq = busReq_ff;
    nxt_busAddr = busAddr_ff;
    nxt_busBurst = busBurst_ff;
    nxt_busWrite = busWrite_ff;
    nxt_cacheN = cacheN_ff;
    nxt_updValid = 1'b0;
    nxt_updAddr = updAddr_ff;
    nxt_updL1St = updL1St_ff;
    nxt_updL2St = updL2St_ff;
    nxt_updL1 = updL1_ff;
    nxt_updL2 = updL2_ff;
    nxt_updL1Wr = updL1Wr_ff;
    nxt_updL2Wr = updL2Wr_ff;
    nxt_opDone = 1'b0;
    case (state_ff)
      tcsc_pkg::ST_IDLE: begin
        if (reqValid) begin
          nxt_wr = reqWrite;
          nxt_instr = reqInstr && !reqSwPrefetch;
          nxt_sw = reqSwPrefetch;
          nxt_cach = reqCacheable;
          nxt_alloc = reqWriteAlloc;
          nxt_pwt = reqPageWt;
          nxt_addr = reqLineAddr;
          nxt_l1 = reqL1State;
          nxt_l2 = reqL2State;
          nxt_fillEx = 1'b0;
          nxt_kenOk = 1'b1;
          nxt_state = tcsc_pkg::ST_PLAN;
        end
      end
      tcsc_pkg::ST_PLAN: begin
        if (plan.burst || plan.singleRead || plan.singleWrite) begin
          nxt_state = tcsc_pkg::ST_ISSUE;
        end else begin
          nxt_updValid = 1'b1; // Hit served inside the caches
          nxt_opDone = 1'b1;
          nxt_state = tcsc_pkg::ST_IDLE;
        end
      end
      tcsc_pkg::ST_ISSUE: begin
        if (startOk) begin
          nxt_busReq = 1'b1;
          nxt_busAddr = addr_ff;
          nxt_busBurst = plan.burst;
          nxt_busWrite = !plan.burst && plan.singleWrite;
          nxt_cacheN = !plan.burst;
          nxt_state = tcsc_pkg::ST_DEMAND;
        end
      end
      tcsc_pkg::ST_DEMAND: begin
        if (busDone) begin
          nxt_busReq = 1'b0;
          nxt_fillEx = !pwt_ff && writebackNotWritethrough;
          if (busBurst_ff) begin
            nxt_kenOk = !lineCacheEnable_n;
            nxt_state = tcsc_pkg::ST_AFTER;
          end else begin
            nxt_updValid = 1'b1;
            nxt_opDone = 1'b1;
            nxt_state = tcsc_pkg::ST_IDLE;
          end
        end
      end
      tcsc_pkg::ST_AFTER: begin
        if (plan.singleWrite || (kenFail && wr_ff)) begin
          nxt_state = tcsc_pkg::ST_GAP;
        end else if (plan.prefetchMate && !kenFail) begin
          nxt_updValid = 1'b1;
          nxt_state = tcsc_pkg::ST_GAP;
        end else begin
          nxt_updValid = 1'b1;
          nxt_opDone = 1'b1;
          nxt_state = tcsc_pkg::ST_IDLE;
        end
      end
      tcsc_pkg::ST_GAP: begin
        if (startOk) begin
          nxt_busReq = 1'b1;
          nxt_cacheN = 1'b1;
          nxt_busBurst = 1'b0;
          nxt_busWrite = 1'b1;
          nxt_busAddr = addr_ff;
          nxt_state = tcsc_pkg::ST_POSTWR;
          if (!wr_ff) begin
            nxt_busAddr = mateAddr;
            nxt_busBurst = 1'b1;
            nxt_busWrite = 1'b0;
            nxt_cacheN = 1'b0;
            nxt_state = tcsc_pkg::ST_MATE;
          end
        end
      end
      tcsc_pkg::ST_MATE: begin
        if (busDone) begin
          nxt_busReq = 1'b0;
          nxt_updValid = 1'b1;
          nxt_opDone = 1'b1;
          nxt_updAddr = mateAddr;
          nxt_updL1 = !lineCacheEnable_n;
          nxt_updL2 = !lineCacheEnable_n;
          nxt_updL1Wr = 1'b0;
          nxt_updL2Wr = 1'b0;
          if (lineCacheEnable_n) begin
            nxt_updL1St = tcsc_pkg::MESI_I;
            nxt_updL2St = tcsc_pkg::MESI_I;
          end else if (!pwt_ff && writebackNotWritethrough) begin
            nxt_updL1St = tcsc_pkg::MESI_E;
            nxt_updL2St = tcsc_pkg::MESI_E;
          end else begin
            nxt_updL1St = tcsc_pkg::MESI_S;
            nxt_updL2St = tcsc_pkg::MESI_S;
          end
          nxt_state = tcsc_pkg::ST_IDLE;
        end
      end
      tcsc_pkg::ST_POSTWR: begin
        if (busDone) begin
          nxt_busReq = 1'b0;
          nxt_busWrite = 1'b0;
          nxt_updValid = 1'b1;
          nxt_opDone = 1'b1;
          nxt_state = tcsc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = tcsc_pkg::ST_IDLE;
      end
    endcase
    // Report of the demanded line itself, a fill refused by cache enable reports no updates, L2 invalid and L1 invalid unless a shared instruction fill gives S
    if (nxt_updValid && state_ff != tcsc_pkg::ST_MATE) begin
      nxt_updAddr = addr_ff;
      nxt_updL1St = kenFail ? tcsc_pkg::MESI_I : plan.l1New;
      nxt_updL2St = kenFail ? tcsc_pkg::MESI_I : plan.l2New;
      nxt_updL1 = plan.updL1 && !kenFail;
      nxt_updL2 = plan.updL2 && !kenFail;
      nxt_updL1Wr = plan.writeL1 && !kenFail;
      nxt_updL2Wr = plan.writeL2 && !kenFail;
      if (plan.updL1 && plan.l1New == tcsc_pkg::MESI_S && !wr_ff && instr_ff) begin
        nxt_updL1St = fx;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= tcsc_pkg::ST_IDLE;
      wr_ff <= 1'b0;
      instr_ff <= 1'b0;
      sw_ff <= 1'b0;
      cach_ff <= 1'b0;
      alloc_ff <= 1'b0;
      pwt_ff <= 1'b0;
      addr_ff <= '0;
      l1_ff <= tcsc_pkg::MESI_I;
      l2_ff <= tcsc_pkg::MESI_I;
      fillEx_ff <= 1'b0;
      kenOk_ff <= 1'b1;
      busReq_ff <= 1'b0;
      busAddr_ff <= '0;
      busBurst_ff <= 1'b0;
      busWrite_ff <= 1'b0;
      cacheN_ff <= 1'b1;
      updValid_ff <= 1'b0;
      updAddr_ff <= '0;
      updL1St_ff <= tcsc_pkg::MESI_I;
      updL2St_ff <= tcsc_pkg::MESI_I;
      updL1_ff <= 1'b0;
      updL2_ff <= 1'b0;
      updL1Wr_ff <= 1'b0;
      updL2Wr_ff <= 1'b0;
      opDone_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wr_ff <= nxt_wr;
      instr_ff <= nxt_instr;
      sw_ff <= nxt_sw;
      cach_ff <= nxt_cach;
      alloc_ff <= nxt_alloc;
      pwt_ff <= nxt_pwt;
      addr_ff <= nxt_addr;
      l1_ff <= nxt_l1;
      l2_ff <= nxt_l2;
      fillEx_ff <= nxt_fillEx;
      kenOk_ff <= nxt_kenOk;
      busReq_ff <= nxt_busReq;
      busAddr_ff <= nxt_busAddr;
      busBurst_ff <= nxt_busBurst;
      busWrite_ff <= nxt_busWrite;
      cacheN_ff <= nxt_cacheN;
      updValid_ff <= nxt_updValid;
      updAddr_ff <= nxt_updAddr;
      updL1St_ff <= nxt_updL1St;
      updL2St_ff <= nxt_updL2St;
      updL1_ff <= nxt_updL1;
      updL2_ff <= nxt_updL2;
      updL1Wr_ff <= nxt_updL1Wr;
      updL2Wr_ff <= nxt_updL2Wr;
      opDone_ff <= nxt_opDone;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busReq = busReq_ff;
  assign busAddr = busAddr_ff;
  assign busBurst = busBurst_ff;
  assign busWrite = busWrite_ff;
  assign cacheCycle_n = cacheN_ff;
  assign pageWritethrough = pwt_ff;
  assign updValid = updValid_ff;
  assign updAddr = updAddr_ff;
  assign updL1State = updL1St_ff;
  assign updL2State = updL2St_ff;
  assign updL1 = updL1_ff;
  assign updL2 = updL2_ff;
  assign updL1Write = updL1Wr_ff;
  assign updL2Write = updL2Wr_ff;
  assign updInstr = instr_ff;
  assign opDone = opDone_ff;

endmodule

// *** tcsc_pkg.sv ***
// Shared types and constants for the two-level cache state control block
package tcsc_pkg;

  // ----------------------------------------------------------------
  // Line geometry
  // ----------------------------------------------------------------
  localparam int LINE_BYTES = 32;
  localparam int BYTE_ADDR_W = 32;
  localparam int LINE_OFS_W = $clog2(LINE_BYTES);
  localparam int LINE_ADDR_W = BYTE_ADDR_W - LINE_OFS_W;
  localparam int SECTOR_SEL_BIT = 0;

  // ----------------------------------------------------------------
  // Line states and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MESI_I,
    MESI_S,
    MESI_E,
    MESI_M
  } tcsc_mesi_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PLAN,
    ST_ISSUE,
    ST_DEMAND,
    ST_AFTER,
    ST_GAP,
    ST_MATE,
    ST_POSTWR
  } tcsc_state_e;

endpackage

// *** tcsc_plan_if.sv ***
// Access plan passed from the state decision logic to the sequencer
`timescale 1ns/1ps
interface tcsc_plan_if;
  logic burst;
  logic singleRead;
  logic singleWrite;
  logic prefetchMate;
  logic fillL1;
  logic fillL2;
  logic writeL1;
  logic writeL2;
  logic updL1;
  logic updL2;
  tcsc_pkg::tcsc_mesi_e l1New;
  tcsc_pkg::tcsc_mesi_e l2New;

  modport calc (
    output burst, singleRead, singleWrite, prefetchMate, fillL1, fillL2,
    output writeL1, writeL2, updL1, updL2, l1New, l2New
  );
  modport ctrl (
    input burst, singleRead, singleWrite, prefetchMate, fillL1, fillL2,
    input writeL1, writeL2, updL1, updL2, l1New, l2New
  );
endinterface

// *** tcsc_state_calc.sv ***
// Access plan and final line states from the looked-up states
`timescale 1ns/1ps
module tcsc_state_calc (
  input wire logic isWrite,
  input wire logic isInstr,
  input wire logic isSwPrefetch,
  input wire logic isCacheable,
  input wire logic writeAlloc,
  input wire logic fillExcl,
  input wire tcsc_pkg::tcsc_mesi_e l1State,
  input wire tcsc_pkg::tcsc_mesi_e l2State,
  tcsc_plan_if.calc plan
);

  tcsc_pkg::tcsc_mesi_e fx;

  // ----------------------------------------------------------------
  // Decision table
  // ----------------------------------------------------------------
  always_comb begin
    fx = fillExcl ? tcsc_pkg::MESI_E : tcsc_pkg::MESI_S;
    plan.burst = 1'b0;
    plan.singleRead = 1'b0;
    plan.singleWrite = 1'b0;
    plan.prefetchMate = 1'b0;
    plan.fillL1 = 1'b0;
    plan.fillL2 = 1'b0;
    plan.writeL1 = 1'b0;
    plan.writeL2 = 1'b0;
    plan.updL1 = 1'b0;
    plan.updL2 = 1'b0;
    plan.l1New = l1State;
    plan.l2New = l2State;
    if (!isWrite) begin
      if (l1State != tcsc_pkg::MESI_I) begin
        plan.l1New = l1State; // Read hit, nothing changes
      end else if (l2State == tcsc_pkg::MESI_I) begin
        if (isCacheable) begin
          plan.burst = 1'b1;
          plan.fillL1 = 1'b1;
          plan.fillL2 = 1'b1;
          plan.updL1 = 1'b1;
          plan.updL2 = 1'b1;
          plan.l1New = fx;
          plan.l2New = fx;
          plan.prefetchMate = !isSwPrefetch;
        end else begin
          plan.singleRead = 1'b1;
          plan.l1New = tcsc_pkg::MESI_I;
          plan.l2New = tcsc_pkg::MESI_I;
        end
      end else begin
        plan.fillL1 = 1'b1;
        plan.updL1 = 1'b1;
        plan.updL2 = 1'b1;
        plan.l1New = l2State;
        plan.l2New = l2State;
        if (l2State == tcsc_pkg::MESI_M) begin
          if (isInstr) begin
            plan.l1New = tcsc_pkg::MESI_E;
            plan.l2New = tcsc_pkg::MESI_M;
          end else begin
            plan.l1New = tcsc_pkg::MESI_M;
            plan.l2New = tcsc_pkg::MESI_E;
          end
        end
      end
    end else if (l1State == tcsc_pkg::MESI_S) begin
      plan.writeL1 = 1'b1;
      plan.singleWrite = 1'b1;
      plan.updL1 = 1'b1;
      plan.l1New = fx;
      if (l2State == tcsc_pkg::MESI_S) begin
        plan.writeL2 = 1'b1;
        plan.updL2 = 1'b1;
        plan.l2New = fx;
      end
    end else if (l1State != tcsc_pkg::MESI_I) begin
      plan.writeL1 = 1'b1;
      plan.updL1 = 1'b1;
      plan.l1New = tcsc_pkg::MESI_M;
    end else if (l2State == tcsc_pkg::MESI_I) begin
      if (writeAlloc && isCacheable) begin
        plan.burst = 1'b1;
        plan.fillL1 = 1'b1;
        plan.fillL2 = 1'b1;
        plan.writeL1 = 1'b1;
        plan.updL1 = 1'b1;
        plan.updL2 = 1'b1;
        if (fillExcl) begin
          plan.l1New = tcsc_pkg::MESI_M;
          plan.l2New = tcsc_pkg::MESI_E;
        end else begin
          plan.writeL2 = 1'b1;
          plan.singleWrite = 1'b1;
          plan.l1New = tcsc_pkg::MESI_S;
          plan.l2New = tcsc_pkg::MESI_S;
        end
      end else begin
        plan.singleWrite = 1'b1;
        plan.l1New = tcsc_pkg::MESI_I;
        plan.l2New = tcsc_pkg::MESI_I;
      end
    end else if (l2State == tcsc_pkg::MESI_S) begin
      plan.writeL2 = 1'b1;
      plan.singleWrite = 1'b1;
      plan.updL2 = 1'b1;
      plan.l2New = fx;
      if (writeAlloc) begin
        plan.fillL1 = 1'b1;
        plan.updL1 = 1'b1;
        plan.l1New = fx;
      end
    end else if (writeAlloc) begin
      plan.fillL1 = 1'b1;
      plan.writeL1 = 1'b1;
      plan.updL1 = 1'b1;
      plan.updL2 = 1'b1;
      plan.l1New = tcsc_pkg::MESI_M;
      plan.l2New = tcsc_pkg::MESI_E;
    end else begin
      plan.writeL2 = 1'b1;
      plan.updL2 = 1'b1;
      plan.l2New = tcsc_pkg::MESI_M;
    end
  end

endmodule

// *** tcsc_bus_gate.sv ***
// Start permission for a new bus cycle, with wait states between bursts
`timescale 1ns/1ps
module tcsc_bus_gate (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic busReady,
  input wire logic priorityPending,
  input wire logic nextCycleRequest_n,
  input wire logic addrBusHold,
  input wire logic busBackoff_n,
  input wire logic inBurst,
  input wire logic between,
  output logic startOk
);

  logic naSeen_ff;
  logic nxt_naSeen;
  logic waited_ff;
  logic nxt_waited;

  // ----------------------------------------------------------------
  // Pipelining permission and forced wait state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_naSeen = naSeen_ff;
    nxt_waited = 1'b0;
    if (inBurst && !nextCycleRequest_n) begin
      nxt_naSeen = 1'b1;
    end
    if (addrBusHold || !busBackoff_n) begin
      nxt_naSeen = 1'b0;
    end
    if (!inBurst && !between) begin
      nxt_naSeen = 1'b0;
    end
    if (between) begin
      nxt_waited = 1'b1;
    end
  end

  // Any hold, back-off or priority access stalls; a missing next-address costs one wait state in the gap
  assign startOk = busReady && !priorityPending && !addrBusHold && busBackoff_n
    && (!between || naSeen_ff || waited_ff);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      naSeen_ff <= 1'b0;
      waited_ff <= 1'b0;
    end else begin
      naSeen_ff <= nxt_naSeen;
      waited_ff <= nxt_waited;
    end
  end

endmodule

// *** tcsc_bus_model.sv ***
// Bus controller model that ends each bus cycle after a set latency
`timescale 1ns/1ps
module tcsc_bus_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic busReq,
  input wire logic [3:0] lat,
  output logic busDone
);
  logic [3:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  // Count up to the latency, then give one done pulse per cycle
  always_comb begin
    nxt_cnt = (busReq && !done_ff) ? cnt_ff + 4'h1 : 4'h0;
    nxt_done = busReq && !done_ff && (cnt_ff >= lat);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end
  assign busDone = done_ff;
endmodule

// *** tcsc_ctrl_chk.sv ***
// Port checker for the cache state control block
`timescale 1ns/1ps
module tcsc_ctrl_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic busReq,
  input wire logic busBurst,
  input wire logic busWrite,
  input wire logic cacheCycle_n,
  input wire logic pageWritethrough,
  input wire logic busReady,
  input wire logic priorityPending,
  input wire logic addrBusHold,
  input wire logic busBackoff_n,
  input wire logic busDone,
  input wire logic lineCacheEnable_n,
  input wire logic writebackNotWritethrough,
  input wire logic updValid,
  input wire logic updL1,
  input wire logic updL2,
  input wire logic updInstr,
  input wire tcsc_pkg::tcsc_mesi_e updL1State,
  input wire tcsc_pkg::tcsc_mesi_e updL2State
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus cycle form and start gating
  a_burst_cacheable: assert property (busReq && busBurst |-> !cacheCycle_n)
    else $error("burst not cacheable");
  a_single_plain: assert property (busReq && !busBurst |-> cacheCycle_n)
    else $error("single marked cacheable");
  a_start_gated: assert property ($rose(busReq) |-> $past(busReady && !priorityPending && !addrBusHold && busBackoff_n))
    else $error("cycle started while blocked");
  a_done_release: assert property (busReq && busDone |=> !busReq)
    else $error("bus cycle held after done");
  // State reports after bus cycles
  a_no_excl_mod: assert property (updValid && updL1 && updL2 && !updInstr && updL1State == tcsc_pkg::MESI_E |-> updL2State != tcsc_pkg::MESI_M)
    else $error("data L1 E with L2 M");
  a_wt_shared: assert property (busDone && busReq && busBurst && !lineCacheEnable_n && (pageWritethrough || !writebackNotWritethrough) |-> ##[1:40] (updValid && updL2State == tcsc_pkg::MESI_S))
    else $error("writethrough fill not shared");
  a_single_read_inv: assert property (busDone && busReq && !busBurst && !busWrite |-> ##[1:3] (updValid && updL1State == tcsc_pkg::MESI_I && updL2State == tcsc_pkg::MESI_I))
    else $error("single read left a line valid");
  a_ken_refused: assert property (busDone && busReq && busBurst && lineCacheEnable_n |-> ##[1:40] (updValid && updL2State == tcsc_pkg::MESI_I))
    else $error("fill without cache enable");
endmodule

bind tcsc_ctrl tcsc_ctrl_chk tcsc_ctrl_chk_i (.*);

// *** testbench.sv ***
// Self-checking bench for the cache state control block
`timescale 1ns/1ps
module testbench;
  localparam tcsc_pkg::tcsc_mesi_e mI = tcsc_pkg::MESI_I;
  localparam tcsc_pkg::tcsc_mesi_e mS = tcsc_pkg::MESI_S;
  localparam tcsc_pkg::tcsc_mesi_e mE = tcsc_pkg::MESI_E;
  localparam tcsc_pkg::tcsc_mesi_e mM = tcsc_pkg::MESI_M;
  logic clock = 1'b0, rst_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqInstr = 1'b0;
  logic reqSwPrefetch = 1'b0, reqCacheable = 1'b0, reqWriteAlloc = 1'b0, reqPageWt = 1'b0;
  logic [26:0] reqLineAddr = 27'h41, busAddr, updAddr;
  logic [26:0] ba [2];
  logic [26:0] ua;
  logic [3:0] fl;
  tcsc_pkg::tcsc_mesi_e reqL1State = mI, reqL2State = mI, updL1State, updL2State, l1, l2;
  logic reqReady, busReq, busBurst, busWrite, cacheCycle_n, pageWritethrough, busDone;
  logic updValid, updL1, updL2, updL1Write, updL2Write, updInstr, opDone;
  logic busReady = 1'b1, priorityPending = 1'b0, nextCycleRequest_n = 1'b0;
  logic addrBusHold = 1'b0, busBackoff_n = 1'b1, lineCacheEnable_n = 1'b0;
  logic writebackNotWritethrough = 1'b1;
  logic [3:0] lat = 4'h1;
  int nBurst, nSingle, nUpd, bad_count = 0, compares = 0;

  tcsc_ctrl tcsc_ctrl_i (.*);
  tcsc_bus_model tcsc_bus_model_i (.clock, .rst_n, .busReq, .lat, .busDone);
  always #2.5 clock = ~clock;

  // Count finished bus cycles and keep the latest state report
  always @(negedge clock) begin
    if (busReq && busDone && busBurst) begin
      ba[nBurst[0]] = busAddr;
      nBurst++;
    end
    if (busReq && busDone && !busBurst) nSingle++;
    if (updValid) begin
      nUpd++;
      l1 = updL1State;
      l2 = updL2State;
      ua = updAddr;
      fl = {updL1, updL2, updL1Write, updL2Write};
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One request: f = write instr swpf cacheable alloc pagewt wbwt
  task automatic run(input logic [6:0] f, input tcsc_pkg::tcsc_mesi_e s1, s2, input int nb,
                     input int ns, input tcsc_pkg::tcsc_mesi_e e1, e2, input logic c2);
    int n;
    @(negedge clock);
    {reqWrite, reqInstr, reqSwPrefetch, reqCacheable, reqWriteAlloc, reqPageWt,
      writebackNotWritethrough} = f;
    reqL1State = s1;
    reqL2State = s2;
    reqValid = 1'b1;
    nBurst = 0;
    nSingle = 0;
    nUpd = 0;
    n = 0;
    @(negedge clock);
    reqValid = 1'b0;
    while (opDone !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    if (n == 300) begin
      bad_count++;
      final_report();
    end
    chk("bursts", nBurst, nb);
    chk("singles", nSingle, ns);
    chk("reported", 32'(nUpd != 0), 1);
    chk("l1State", 32'(l1), 32'(e1));
    if (c2) chk("l2State", 32'(l2), 32'(e2));
  endtask

  task automatic t_l2hit;
    run(7'h09, mI, mE, 0, 0, mE, mE, 1'b1);
    run(7'h09, mI, mS, 0, 0, mS, mS, 1'b1);
    run(7'h09, mI, mM, 0, 0, mM, mE, 1'b1);
    run(7'h29, mI, mM, 0, 0, mE, mM, 1'b1);
    $display("l2 hit reads done");
  endtask

  task automatic t_fill;
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      reqLineAddr = 27'h2A;
      lat = 4'(k * 3);
      nextCycleRequest_n = k[0];
      addrBusHold = (k == 0);
      busBackoff_n = (k != 1);
      priorityPending = (k == 2);
      fork
        run(7'h09, mI, mI, 2, 0, mE, mE, 1'b1);
        begin
          repeat (6) @(negedge clock);
          addrBusHold = 1'b0;
          busBackoff_n = 1'b1;
          priorityPending = 1'b0;
        end
      join
      chk("demandAddr", 32'(ba[0]), 32'h2A);
      chk("mateAddr", 32'(ba[1]), 32'h2B);
      chk("mateReport", 32'(ua), 32'h2B);
      chk("mateFlags", 32'(fl), 32'hC);
    end
    $display("sector fill done");
  endtask

  task automatic t_swpf;
    run(7'h39, mI, mI, 1, 0, mE, mE, 1'b1);
    chk("prefetchAddr", 32'(ba[0]), 32'h2A);
    chk("instrSide", 32'(updInstr), 0);
    $display("software prefetch done");
  endtask

  task automatic t_nofill;
    run(7'h01, mI, mI, 0, 1, mI, mI, 1'b1);
    @(negedge clock);
    lineCacheEnable_n = 1'b1;
    run(7'h09, mI, mI, 1, 0, mI, mI, 1'b1);
    @(negedge clock);
    lineCacheEnable_n = 1'b0;
    run(7'h0B, mI, mI, 2, 0, mS, mS, 1'b1);
    chk("pageWt", 32'(pageWritethrough), 1);
    run(7'h08, mI, mI, 2, 0, mS, mS, 1'b1);
    $display("uncached and writethrough reads done");
  endtask

  task automatic t_write;
    run(7'h49, mI, mI, 0, 1, mI, mI, 1'b1);
    chk("noUpdFlags", 32'(fl), 32'h0);
    run(7'h4D, mI, mI, 1, 0, mM, mE, 1'b1);
    chk("allocFlags", 32'(fl), 32'hE);
    run(7'h4C, mI, mI, 1, 1, mS, mS, 1'b1);
    chk("wtFlags", 32'(fl), 32'hF);
    run(7'h49, mS, mI, 0, 1, mE, mI, 1'b0);
    run(7'h49, mE, mE, 0, 0, mM, mI, 1'b0);
    run(7'h49, mM, mI, 0, 0, mM, mI, 1'b0);
    run(7'h49, mS, mS, 0, 1, mE, mE, 1'b1);
    run(7'h48, mS, mS, 0, 1, mS, mS, 1'b1);
    run(7'h49, mI, mE, 0, 0, mI, mM, 1'b1);
    run(7'h49, mI, mS, 0, 1, mI, mE, 1'b1);
    run(7'h49, mI, mM, 0, 0, mI, mM, 1'b1);
    run(7'h4D, mI, mM, 0, 0, mM, mE, 1'b1);
    run(7'h4D, mI, mE, 0, 0, mM, mE, 1'b1);
    run(7'h4D, mI, mS, 0, 1, mE, mE, 1'b1);
    $display("writes done");
  endtask

  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    t_l2hit();
    t_fill();
    t_swpf();
    t_nofill();
    t_write();
    final_report();
  end
endmodule
